// ===== tch_bitphy.sv
// Bit level I2C master: START, byte transfer with ACK, STOP.
// Assumes pins synchronised here; bus pulled up outside.
module tch_bitphy
    import tch_pkg::*;
#(
    parameter int HALF_CYC    = tch_pkg::SCL_HALF_CYC,
    parameter int STRETCH_MAX = tch_pkg::STRETCH_CYC
)
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    // Command side
    input  wire logic       cmd_valid_in,
    input  wire tch_cmd_t   cmd_in,
    input  wire logic [7:0] cmd_data_in,
    input  wire logic       cmd_nack_in,
    output logic            cmd_ready_out,
    output logic            done_out,
    output logic [7:0]      rx_data_out,
    output logic            rx_ack_out,
    output logic            stretch_err_out,
    // Pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            scl_oe_out,
    output logic            sda_oe_out
);
    typedef enum logic [2:0] {
        PH_IDLE, PH_LOW, PH_HIGH, PH_WAIT, PH_DONE
    } tch_ph_t;
    // Refuse timings that the phase logic cannot serve
    if (HALF_CYC < 2 || STRETCH_MAX < 1)
    begin : g_bad_param
        $error("tch_bitphy: HALF_CYC or STRETCH_MAX too small");
    end
    logic [1:0]  scl_s_ff, sda_s_ff;
    tch_ph_t     ph_ff, nxt_ph;
    tch_cmd_t    op_ff, nxt_op;
    logic [3:0]  bit_ff, nxt_bit;
    logic [8:0]  sh_ff, nxt_sh;
    logic [31:0] cnt_ff, nxt_cnt;
    logic        scl_oe_ff, nxt_scl_oe, sda_oe_ff, nxt_sda_oe;
    logic        done_ff, nxt_done, err_ff, nxt_err;
    logic        nack_ff, nxt_nack;
    logic        scl_s, sda_s;
    assign scl_s = scl_s_ff[1];
    assign sda_s = sda_s_ff[1];

    // Next phase; a byte is nine SCL pulses including ACK
    always_comb
    begin
        nxt_ph = ph_ff; nxt_op = op_ff; nxt_bit = bit_ff; nxt_sh = sh_ff;
        nxt_cnt = cnt_ff + 32'd1; nxt_scl_oe = scl_oe_ff;
        nxt_sda_oe = sda_oe_ff; nxt_done = 1'b0; nxt_err = err_ff;
        nxt_nack = nack_ff;
        case (ph_ff)
            PH_IDLE:
            begin
                nxt_cnt = '0;
                if (cmd_valid_in)
                begin
                    nxt_op = cmd_in; nxt_bit = 4'd0; nxt_err = 1'b0;
                    nxt_nack = cmd_nack_in;
                    // Ninth bit: 1 releases SDA, 0 drives an ACK
                    nxt_sh = {cmd_data_in, cmd_nack_in};
                    nxt_ph = PH_LOW;
                end
            end
            PH_LOW:
            begin
                nxt_scl_oe = 1'b1;
                // SDA moves only once SCL is low, so no false START/STOP
                if (!scl_oe_ff)
                    nxt_sda_oe = sda_oe_ff;
                else if (op_ff == TCH_CMD_START)
                    nxt_sda_oe = 1'b0;
                else if (op_ff == TCH_CMD_STOP)
                    nxt_sda_oe = 1'b1;
                else if (bit_ff == 4'd8)
                    nxt_sda_oe = ~sh_ff[8];
                else
                    nxt_sda_oe = ~sh_ff[8];
                if (cnt_ff >= 32'(HALF_CYC))
                begin
                    nxt_cnt = '0; nxt_scl_oe = 1'b0; nxt_ph = PH_WAIT;
                end
            end
            PH_WAIT:
            begin
                // Device may hold SCL low while busy, bounded
                nxt_scl_oe = 1'b0;
                if (scl_s)
                begin
                    nxt_cnt = '0; nxt_ph = PH_HIGH;
                end
                else if (cnt_ff >= 32'(STRETCH_MAX))
                begin
                    nxt_err = 1'b1; nxt_ph = PH_DONE;
                end
            end
            PH_HIGH:
            begin
                if (cnt_ff >= 32'(HALF_CYC))
                begin
                    nxt_cnt = '0;
                    if (op_ff == TCH_CMD_START)
                    begin
                        // SCL falls later, in the next byte's low phase
                        nxt_sda_oe = 1'b1;
                        nxt_ph = PH_DONE;
                    end
                    else if (op_ff == TCH_CMD_STOP)
                    begin
                        nxt_sda_oe = 1'b0; nxt_ph = PH_DONE;
                    end
                    else
                    begin
                        nxt_sh = {sh_ff[7:0], sda_s};
                        nxt_bit = bit_ff + 4'd1;
                        nxt_scl_oe = 1'b1;
                        if (bit_ff == 4'd7)
                            nxt_sh = {sh_ff[7:0], nack_ff};
                        nxt_ph = (bit_ff == 4'd8) ? PH_DONE : PH_LOW;
                        if (bit_ff == 4'd7)
                            nxt_sh[0] = nack_ff;
                    end
                end
            end
            PH_DONE:
            begin
                nxt_done = 1'b1; nxt_ph = PH_IDLE;
            end
            default: nxt_ph = PH_IDLE;
        endcase
    end

    // Capture of received bits: keep sampled byte separately
    logic [7:0] rx_ff, nxt_rx;
    logic       ack_ff, nxt_ack;
    always_comb
    begin
        nxt_rx = rx_ff; nxt_ack = ack_ff;
        if (ph_ff == PH_HIGH && cnt_ff >= 32'(HALF_CYC) &&
            op_ff == TCH_CMD_BYTE)
        begin
            if (bit_ff < 4'd8)
                nxt_rx = {rx_ff[6:0], sda_s};
            else
                nxt_ack = ~sda_s;
        end
    end

    // Registers; pins sampled through two flops first
    always_ff @(posedge clk_in)
    begin
        if (!resetn_in)
        begin
            scl_s_ff <= 2'b11; sda_s_ff <= 2'b11; ph_ff <= PH_IDLE;
            op_ff <= TCH_CMD_START; bit_ff <= '0; sh_ff <= '1;
            cnt_ff <= '0; scl_oe_ff <= 1'b0; sda_oe_ff <= 1'b0;
            done_ff <= 1'b0; err_ff <= 1'b0; nack_ff <= 1'b0;
            rx_ff <= '0; ack_ff <= 1'b0;
        end
        else
        begin
            scl_s_ff <= {scl_s_ff[0], scl_in};
            sda_s_ff <= {sda_s_ff[0], sda_in};
            ph_ff <= nxt_ph; op_ff <= nxt_op; bit_ff <= nxt_bit;
            sh_ff <= nxt_sh; cnt_ff <= nxt_cnt; scl_oe_ff <= nxt_scl_oe;
            sda_oe_ff <= nxt_sda_oe; done_ff <= nxt_done; err_ff <= nxt_err;
            nack_ff <= nxt_nack; rx_ff <= nxt_rx; ack_ff <= nxt_ack;
        end
    end
    assign cmd_ready_out   = (ph_ff == PH_IDLE);
    assign done_out        = done_ff;
    assign rx_data_out     = rx_ff;
    assign rx_ack_out      = ack_ff;
    assign stretch_err_out = err_ff;
    assign scl_oe_out      = scl_oe_ff;
    assign sda_oe_out      = sda_oe_ff;
endmodule

// ===== tch_dev_model.sv
// Behavioural touch device: I2C target with pointer and byte log.
// Assumes the bench resolves the open-drain wires; never stretches SCL.
module tch_dev_model
    import tch_pkg::*;
(
    // Bus wires
    input  wire logic   scl_in,
    input  wire logic   sda_in,
    output logic        sda_oe_out,
    // Observation of the last write
    output logic [7:0]  hi_out,
    output logic [7:0]  last_out,
    output logic [15:0] ptr_out,
    output int          nbytes_out
);
    int          pcnt;
    logic [7:0]  sh;
    logic [7:0]  dat;
    logic        sel;
    logic        rd;
    logic [15:0] base;
    initial
    begin
        {sda_oe_out, sel, rd, ptr_out, base} = '0;
        pcnt = 0;
    end
    // START opens a frame; the address byte is counted as index 0
    always @(negedge sda_in)
        if (scl_in)
        begin
            pcnt = 0;
            nbytes_out = -1;
        end
    // STOP rewinds the pointer to where the transfer began
    always @(posedge sda_in)
        if (scl_in)
        begin
            sel = 1'b0;
            ptr_out = base;
        end
    // Sample data; a host NACK in a read rewinds and lets go of the bus
    always @(posedge scl_in)
    begin
        if (pcnt < 8)
            sh = {sh[6:0], sda_in};
        else if (rd && sel && sda_in)
        begin
            ptr_out = base;
            sel = 1'b0;
        end
        pcnt = pcnt + 1;
    end
    // Drive only while SCL is low, so START and STOP are never faked
    always @(negedge scl_in)
    begin
        if (pcnt == 8)
        begin
            if (rd && sel)
                sda_oe_out = 1'b0;
            else
            begin
                nbytes_out = nbytes_out + 1;
                if (nbytes_out == 0)
                begin
                    sel = (sh[7:1] == TARGET_ADDR);
                    rd = sh[0];
                end
                if (nbytes_out == 1)
                    base[7:0] = sh;
                if (nbytes_out == 2)
                begin
                    hi_out = sh;
                    base[15:8] = sh & 8'h7f;
                    ptr_out = base;
                end
                last_out = sh; // Kept whatever the CRC says
                sda_oe_out = sel;
            end
        end
        else if (pcnt == 9)
        begin
            pcnt = 0;
            sda_oe_out = 1'b0;
            if (rd && sel)
            begin
                dat = ptr_out[7:0] ^ 8'h5a;
                ptr_out = ptr_out + 16'h0001;
            end
        end
        if (rd && sel && pcnt < 8)
            sda_oe_out = !dat[7 - pcnt];
    end
endmodule

// ===== tch_host.sv
// Host controller for the touch controller's I2C target protocol.
// Assumes software drives the plain register port; pins are open drain.
module tch_host
    import tch_pkg::*;
#(
    parameter int HALF_CYC    = tch_pkg::SCL_HALF_CYC,
    parameter int STRETCH_MAX = tch_pkg::STRETCH_CYC
)
(
    // Clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RESETN_IN,
    // Register port
    input  wire logic [3:0]  ADDR_IN,
    input  wire logic [15:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic [15:0]      RDATA_OUT,
    // I2C pins
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic             SCL_OE_OUT,
    output logic             SDA_OE_OUT,
    // Pending line from the device
    input  wire logic        MESSAGE_PENDING_N_IN
);
    import tch_pkg::*;
    typedef enum logic [3:0] {
        ST_IDLE, ST_START, ST_ADDR, ST_PTR_LO, ST_PTR_HI, ST_SIZE,
        ST_DATA, ST_CRC, ST_PAD, ST_RSTART, ST_RADDR, ST_RBYTE, ST_STOP
    } tch_st_t;

    logic [15:0] ptr_ff, nxt_ptr, size_ff, nxt_size;
    logic [7:0]  wdata_ff, nxt_wdata, rdata_ff, nxt_rdata;
    logic [7:0]  crc_ff, nxt_crc, cnt_ff, nxt_cnt, left_ff, nxt_left;
    logic [4:0]  ctrl_ff, nxt_ctrl;
    logic [7:0]  blk_ff, nxt_blk;
    logic        busy_ff, nxt_busy, nack_ff, nxt_nack, rdv_ff, nxt_rdv;
    logic        sret_ff, nxt_sret, inv_ff, nxt_inv, szb_ff, nxt_szb;
    logic        pend_s0_ff, pend_s1_ff;
    logic [15:0] rd_ff, nxt_rd;
    tch_st_t     st_ff, nxt_st;
    logic        issued_ff, nxt_issued;
    logic        p_valid, p_ready, p_done, p_ack, p_err, p_nack;
    tch_cmd_t    p_cmd;
    logic [7:0]  p_data, p_rx;

    tch_bitphy #(.HALF_CYC(HALF_CYC), .STRETCH_MAX(STRETCH_MAX)) u_phy (
        .clk_in          (CLK_IN),
        .resetn_in       (RESETN_IN),
        .cmd_valid_in    (p_valid),
        .cmd_in          (p_cmd),
        .cmd_data_in     (p_data),
        .cmd_nack_in     (p_nack),
        .cmd_ready_out   (p_ready),
        .done_out        (p_done),
        .rx_data_out     (p_rx),
        .rx_ack_out      (p_ack),
        .stretch_err_out (p_err),
        .scl_in          (SCL_IN),
        .sda_in          (SDA_IN),
        .scl_oe_out      (SCL_OE_OUT),
        .sda_oe_out      (SDA_OE_OUT)
    );

    // Byte command for the current state
    always_comb
    begin
        p_valid = busy_ff && !issued_ff && p_ready;
        // Ninth bit released by default so the device can ACK
        p_cmd = TCH_CMD_BYTE; p_data = 8'h00; p_nack = 1'b1;
        case (st_ff)
            ST_START, ST_RSTART: p_cmd = TCH_CMD_START;
            ST_STOP:   p_cmd = TCH_CMD_STOP;
            ST_ADDR:   p_data = {TARGET_ADDR, 1'b0};
            ST_RADDR:  p_data = {TARGET_ADDR, 1'b1};
            ST_PTR_LO: p_data = ptr_ff[7:0];
            ST_PTR_HI: p_data = ptr_ff[15:8] | (ctrl_ff[CTRL_CKSUM] ?
                                CKSUM_BIT : 8'h00);
            ST_SIZE:   p_data = szb_ff ? size_ff[15:8] : size_ff[7:0];
            ST_DATA:   p_data = wdata_ff;
            ST_CRC:    p_data = crc_ff;
            ST_PAD:    p_data = 8'h00;
            ST_RBYTE:
            begin
                // Leave SDA to the device; ACK all bytes but the last
                p_data = 8'hff;
                p_nack = (left_ff == 8'd1);
            end
            default:   p_valid = 1'b0;
        endcase
    end

    // Sequencer and register port
    always_comb
    begin
        nxt_st = st_ff; nxt_ptr = ptr_ff; nxt_size = size_ff;
        nxt_wdata = wdata_ff; nxt_rdata = rdata_ff; nxt_crc = crc_ff;
        nxt_cnt = cnt_ff; nxt_left = left_ff; nxt_ctrl = ctrl_ff;
        nxt_busy = busy_ff; nxt_nack = nack_ff; nxt_rdv = rdv_ff;
        nxt_sret = sret_ff; nxt_inv = inv_ff; nxt_szb = szb_ff;
        nxt_blk = blk_ff; nxt_issued = issued_ff; nxt_rd = 16'h0000;
        if (p_valid)
            nxt_issued = 1'b1;
        if (WR_IN && !busy_ff)
        begin
            case (ADDR_IN)
                REG_CTRL:
                begin
                    nxt_ctrl = WDATA_IN[4:0];
                    if (WDATA_IN[CTRL_GO])
                    begin
                        nxt_busy = 1'b1; nxt_st = ST_START;
                        nxt_nack = 1'b0; nxt_sret = 1'b0; nxt_inv = 1'b0;
                        nxt_crc = CRC_INIT; nxt_rdv = 1'b0;
                        // At least one byte per read
                        nxt_left = (WDATA_IN[CTRL_READ] && cnt_ff == 8'd0)
                                   ? 8'd1 : cnt_ff;
                    end
                end
                REG_PTR:   nxt_ptr = WDATA_IN;
                REG_COUNT: nxt_cnt = WDATA_IN[7:0];
                REG_WDATA: nxt_wdata = WDATA_IN[7:0];
                REG_SIZE:  nxt_size = WDATA_IN;
                default:   nxt_rd = 16'h0000;
            endcase
        end
        if (RD_IN)
        begin
            case (ADDR_IN)
                REG_CTRL:   nxt_rd = {11'h000, ctrl_ff};
                REG_PTR:    nxt_rd = ptr_ff;
                REG_COUNT:  nxt_rd = {8'h00, cnt_ff};
                REG_RDATA:  nxt_rd = {8'h00, rdata_ff};
                REG_STATUS: nxt_rd = {10'h000, pend_s1_ff ? 1'b0 : 1'b1,
                                      inv_ff, sret_ff, nack_ff, rdv_ff,
                                      busy_ff};
                REG_SIZE:   nxt_rd = size_ff;
                REG_CRC:    nxt_rd = {8'h00, crc_ff};
                default:    nxt_rd = 16'h0000;
            endcase
            if (ADDR_IN == REG_RDATA)
                nxt_rdv = 1'b0;
        end
        if (busy_ff && p_done)
        begin
            nxt_issued = 1'b0;
            // A stretch fault during STOP still ends the transfer
            if (p_err && st_ff != ST_STOP)
            begin
                nxt_sret = 1'b1; nxt_st = ST_STOP;
            end
            else
            case (st_ff)
                ST_START:  nxt_st = ctrl_ff[CTRL_READ] ? ST_RADDR : ST_ADDR;
                ST_ADDR:   nxt_st = p_ack ? ST_PTR_LO : ST_STOP;
                ST_PTR_LO:
                begin
                    nxt_crc = crc_step(crc_ff, ptr_ff[7:0]);
                    nxt_st = ST_PTR_HI;
                end
                ST_PTR_HI:
                begin
                    nxt_crc = crc_step(crc_ff, ptr_ff[15:8] |
                        (ctrl_ff[CTRL_CKSUM] ? CKSUM_BIT : 8'h00));
                    nxt_szb = 1'b0; nxt_blk = 8'd0;
                    if (ctrl_ff[CTRL_ENC])
                        nxt_st = ST_SIZE;
                    else if (cnt_ff != 8'd0)
                        nxt_st = ST_DATA;
                    else
                        nxt_st = ctrl_ff[CTRL_CKSUM] ? ST_CRC : ST_STOP;
                end
                ST_SIZE:
                begin
                    nxt_crc = crc_step(crc_ff,
                        szb_ff ? size_ff[15:8] : size_ff[7:0]);
                    nxt_szb = 1'b1;
                    if (szb_ff)
                        nxt_st = (cnt_ff != 8'd0) ? ST_DATA :
                                 (ctrl_ff[CTRL_CKSUM] ? ST_CRC : ST_STOP);
                end
                ST_DATA:
                begin
                    // One data byte per write transfer from WDATA
                    nxt_crc = crc_step(crc_ff, wdata_ff);
                    nxt_blk = blk_ff + 8'd1;
                    nxt_st = ctrl_ff[CTRL_CKSUM] ? ST_CRC :
                             (ctrl_ff[CTRL_ENC] ? ST_PAD : ST_STOP);
                end
                ST_CRC:
                begin
                    nxt_blk = blk_ff + 8'd1;
                    nxt_st = (ctrl_ff[CTRL_ENC] && cnt_ff != 8'd0)
                             ? ST_PAD : ST_STOP;
                end
                ST_PAD:
                begin
                    // Fill the data block to 16 bytes
                    nxt_blk = blk_ff + 8'd1;
                    if (blk_ff + 8'd1 >= 8'(ENC_BLOCK))
                        nxt_st = ST_STOP;
                end
                ST_RADDR:  nxt_st = p_ack ? ST_RBYTE : ST_STOP;
                ST_RBYTE:
                begin
                    nxt_rdata = p_rx; nxt_rdv = 1'b1;
                    nxt_left = left_ff - 8'd1;
                    // Bulk reads flag an invalid id but keep reading
                    if (ctrl_ff[CTRL_BULK] && p_rx == INVALID_ID)
                        nxt_inv = 1'b1;
                    if (left_ff == 8'd1)
                        nxt_st = ST_STOP;
                end
                ST_STOP:
                begin
                    nxt_busy = 1'b0; nxt_st = ST_IDLE;
                end
                default: nxt_st = ST_IDLE;
            endcase
            if ((st_ff == ST_ADDR || st_ff == ST_RADDR) && !p_ack)
                nxt_nack = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            st_ff <= ST_IDLE; ptr_ff <= '0; size_ff <= '0; wdata_ff <= '0;
            rdata_ff <= '0; crc_ff <= CRC_INIT; cnt_ff <= '0; left_ff <= '0;
            ctrl_ff <= '0; busy_ff <= 1'b0; nack_ff <= 1'b0; rdv_ff <= 1'b0;
            sret_ff <= 1'b0; inv_ff <= 1'b0; szb_ff <= 1'b0; blk_ff <= '0;
            issued_ff <= 1'b0; rd_ff <= '0;
            pend_s0_ff <= 1'b1; pend_s1_ff <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st; ptr_ff <= nxt_ptr; size_ff <= nxt_size;
            wdata_ff <= nxt_wdata; rdata_ff <= nxt_rdata; crc_ff <= nxt_crc;
            cnt_ff <= nxt_cnt; left_ff <= nxt_left; ctrl_ff <= nxt_ctrl;
            busy_ff <= nxt_busy; nack_ff <= nxt_nack; rdv_ff <= nxt_rdv;
            sret_ff <= nxt_sret; inv_ff <= nxt_inv; szb_ff <= nxt_szb;
            blk_ff <= nxt_blk; issued_ff <= nxt_issued; rd_ff <= nxt_rd;
            pend_s0_ff <= MESSAGE_PENDING_N_IN;
            pend_s1_ff <= pend_s0_ff;
        end
    end
    assign RDATA_OUT = rd_ff;

    // Checks on the host's own sequencing
    chk_addr_byte: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        p_valid && st_ff == ST_ADDR |-> p_data == 8'h94)
        else $error("write address byte wrong");
    chk_read_addr: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        p_valid && st_ff == ST_RADDR |-> p_data == 8'h95)
        else $error("read address byte wrong");
    chk_ptr_order: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        busy_ff && p_done && !p_err && st_ff == ST_PTR_LO
        |=> st_ff == ST_PTR_HI)
        else $error("pointer bytes out of order");
    chk_cksum_bit: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        p_valid && st_ff == ST_PTR_HI && ctrl_ff[CTRL_CKSUM]
        |-> p_data[7])
        else $error("checksum bit missing");
    chk_size_enc: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        st_ff == ST_SIZE |-> ctrl_ff[CTRL_ENC])
        else $error("size bytes without encryption");
    chk_pad_limit: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        st_ff == ST_PAD |-> blk_ff < 8'd16)
        else $error("padding past 16 bytes");
    chk_read_min: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        st_ff == ST_RBYTE |-> left_ff != 8'd0)
        else $error("read with no byte");
    chk_last_nack: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        p_valid && st_ff == ST_RBYTE |-> p_nack == (left_ff == 8'd1))
        else $error("nack misplaced");
    cov_write: cover property (@(posedge CLK_IN) st_ff == ST_DATA);
    cov_crc:   cover property (@(posedge CLK_IN) st_ff == ST_CRC);
    chk_read_free: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        p_valid && st_ff == ST_RBYTE |-> p_data == 8'hff)
        else $error("host drives SDA in a read byte");
    cov_read:  cover property (@(posedge CLK_IN) st_ff == ST_RBYTE);
    cov_bulk:  cover property (@(posedge CLK_IN) inv_ff);
endmodule

// ===== tch_host_test.sv
// Self-checking bench: host controller against a behavioural device.
// Assumes the device acks promptly; random stimulus from a fixed seed.
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
    num_errors++; $display("Error t=%0t got %h exp %h", $time, (a), (b)); \
    end end
module tch_host_test;
    timeunit 1ns;
    timeprecision 1ps;
    import tch_pkg::*;
    logic        clk = 0, resetn = 0, wr = 0, rd = 0, pend_n = 1, hold = 0;
    logic [3:0]  addr = '0;
    logic [15:0] wdata = '0, rdata, st, p, dptr;
    logic        scl_oe, sda_oe, dev_oe, scl, sda;
    logic [7:0]  hi, last, b, c;
    int          nb, k, seed = 32'h8b20, num_errors = 0, samples_checked = 0;
    // Open-drain wires with pull-ups
    assign scl = !(scl_oe || hold);
    assign sda = !(sda_oe || dev_oe);
    initial forever #2.5 clk = !clk;
    tch_host #(.HALF_CYC(4), .STRETCH_MAX(200)) uut (.CLK_IN(clk),
        .RESETN_IN(resetn), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
        .RD_IN(rd), .RDATA_OUT(rdata), .SCL_IN(scl), .SDA_IN(sda),
        .SCL_OE_OUT(scl_oe), .SDA_OE_OUT(sda_oe),
        .MESSAGE_PENDING_N_IN(pend_n));
    tch_dev_model dev (.scl_in(scl), .sda_in(sda), .sda_oe_out(dev_oe),
        .hi_out(hi), .last_out(last), .ptr_out(dptr), .nbytes_out(nb));
    task automatic tally_and_finish();
        $display("Checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One-cycle register strobes
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Launch a transfer, then poll busy; a hang counts as a mismatch
    task automatic run(input logic [15:0] ptr, input int cnt, input int ct);
        wreg(REG_PTR, ptr);
        wreg(REG_COUNT, 16'(cnt));
        wreg(REG_WDATA, {8'h00, b});
        wreg(REG_SIZE, 16'(cnt));
        wreg(REG_CTRL, 16'(ct) | 16'h0001);
        for (int i = 0; i < 4000; i++)
        begin
            rreg(REG_STATUS, st);
            if (st[0] === 1'b0)
                return;
        end
        num_errors++;
        tally_and_finish();
    endtask
    // Reference CRC, bit by bit, LSB first
    function automatic logic [7:0] crc8(input logic [7:0] r,
                                        input logic [7:0] d);
        for (int i = 0; i < 8; i++)
            r = (r[0] ^ d[i]) ? (r >> 1) ^ CRC_POLY : r >> 1;
        return r;
    endfunction
    initial
    begin
        repeat (20) @(posedge clk);
        `CHK({scl_oe, sda_oe}, 2'b00)
        resetn <= 1'b1;
        rreg(4'hf, st);
        `CHK(st, 16'h0000)
        for (int n = 0; n < 8; n++)
        begin
            p = 16'($random(seed)) & 16'h7fff;
            b = 8'($random(seed));
            pend_n <= b[0];
            c = n[0] ? 8'h04 : 8'h00;
            run(p, 1, c);
            `CHK(st[5], !b[0])
            `CHK(nb, c ? 4 : 3)
            `CHK(hi, p[15:8] | {c[2], 7'h00})
            `CHK(dptr, p)
            `CHK(last, c ? crc8(crc8(crc8(CRC_INIT, p[7:0]),
                p[15:8] | 8'h80), b) : b)
            run(p, 0, 0);
            `CHK(nb, 2)
            k = 1 + $unsigned($random(seed)) % 4;
            run(p, k, 2);
            `CHK(st[2:1], 2'b01)
            rreg(REG_RDATA, st);
            `CHK(st[7:0], 8'(p[7:0] + k - 1) ^ 8'h5a)
            `CHK(dptr, p)
        end
        // Encrypted writes: size bytes, then padding only when data exist
        run(p, 1, 8);
        `CHK(nb, 20)
        run(p, 1, 12);
        `CHK(nb, 20)
        run(p, 0, 8);
        `CHK(nb, 4)
        // Bulk read that meets an invalid report id first
        run(16'h00a5, 0, 4);
        run(16'h00a5, 2, 18);
        `CHK(st[4], 1'b1)
        `CHK(dptr, 16'h00a5)
        rreg(REG_RDATA, st);
        `CHK(st[7:0], 8'ha6 ^ 8'h5a)
        // SCL held low too long ends the transfer with a stretch fault
        hold <= 1'b1;
        run(p, 0, 0);
        `CHK(st[3], 1'b1)
        tally_and_finish();
    end
endmodule

// ===== tch_pkg.sv
// Package for the touch controller host-side I2C controller.
// Assumes one 200 MHz system clock; the I2C link is open drain on pins.
// Summary of operation
// - Target address fixed, shifted, bit0 is direction
// - Pointer sent low byte then high byte
// - Two size bytes follow pointer when encrypted
// - Optional trailing CRC covers all bytes after address
// - Encrypted writes padded to 16 bytes by host; the host pads only when COUNT is nonzero
// - Pointer top bit requests checksum mode
// - Read is pointer write then separate read
// - Every read transfer reads at least one byte
// - Bulk read points at count, reads count first
// - Bulk length is count times size or 16
// - Subtract one per message without checksum
// - No START/STOP between messages in bulk read
// - Report id 255 means no message pending
package tch_pkg;
    localparam logic [6:0] TARGET_ADDR   = 7'h4a;
    localparam logic [7:0] CKSUM_BIT     = 8'h80;
    localparam logic [7:0] INVALID_ID    = 8'hff;
    localparam int         MSG_DATA_LEN  = 9;
    localparam int         ENC_BLOCK     = 16;
    localparam logic [7:0] CRC_POLY      = 8'h8c;
    localparam logic [7:0] CRC_INIT      = 8'h00;
    localparam int         CLK_MHZ       = 200;
    localparam int         SCL_HALF_NS   = 1250;
    localparam int         SCL_HALF_CYC  = (SCL_HALF_NS * CLK_MHZ) / 1000;
    localparam int         STRETCH_US    = 2000;
    localparam int         STRETCH_CYC   = STRETCH_US * CLK_MHZ;
    // Register offsets of the host's own command port
    localparam logic [3:0] REG_CTRL      = 4'h0;
    localparam logic [3:0] REG_PTR       = 4'h1;
    localparam logic [3:0] REG_COUNT     = 4'h2;
    localparam logic [3:0] REG_WDATA     = 4'h3;
    localparam logic [3:0] REG_RDATA     = 4'h4;
    localparam logic [3:0] REG_STATUS    = 4'h5;
    localparam logic [3:0] REG_SIZE      = 4'h6;
    localparam logic [3:0] REG_CRC       = 4'h7;
    // Control field positions
    localparam int         CTRL_GO       = 0;
    localparam int         CTRL_READ     = 1;
    localparam int         CTRL_CKSUM    = 2;
    localparam int         CTRL_ENC      = 3;
    localparam int         CTRL_BULK     = 4;
    typedef enum logic [1:0] {
        TCH_CMD_START,
        TCH_CMD_BYTE,
        TCH_CMD_STOP
    } tch_cmd_t;
    // One CRC step over a byte, LSB first
    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic [7:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
        begin
            if (r[0] ^ d[i])
                r = (r >> 1) ^ CRC_POLY;
            else
                r = r >> 1;
        end
        return r;
    endfunction
endpackage
